// >>> inc/pdpd_pkg.sv
/*
  shared constants and types for the positioning flags and pulse divider block.
  assumes a single 100 MHz clock and an AXI4-Lite register slave.
*/
package pdpd_pkg;
  localparam int          CLK_HZ        = 100_000_000;
  localparam int          OC_MAX_HZ     = 3_000;
  localparam int          OC_GAP_CYC    = (CLK_HZ + OC_MAX_HZ - 1) / OC_MAX_HZ;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_APPR_THR = 8'h04;
  localparam logic [7:0]  ADDR_DONE_THR = 8'h08;
  localparam logic [7:0]  ADDR_HOLD     = 8'h0C;
  localparam logic [7:0]  ADDR_DIV      = 8'h10;
  localparam logic [7:0]  ADDR_DO_SEL   = 8'h14;
  localparam logic [7:0]  ADDR_STATUS   = 8'h18;
  localparam logic [7:0]  ADDR_APPLY    = 8'h1C;
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_DSEL_LSB = 2;
  localparam int          CTRL_SRC_LSB  = 4;
  localparam int          CTRL_DIR_BIT  = 6;
  localparam int          DOB_LSB       = 8;
  localparam logic [4:0]  FUNC_DONE     = 5'h0D;
  localparam logic [4:0]  FUNC_CLOSE    = 5'h0E;
  localparam logic [1:0]  MODE_OFF      = 2'h0;
  localparam logic [1:0]  MODE_SPD      = 2'h1;
  localparam logic [1:0]  MODE_FILT     = 2'h2;
  localparam logic [1:0]  MODE_LATCH    = 2'h3;
  localparam logic [1:0]  DSEL_FUNC     = 2'h0;
  localparam logic [1:0]  DSEL_PULSE    = 2'h1;
  localparam logic [1:0]  SRC_MOTOR     = 2'h0;
  localparam logic [1:0]  SRC_CMD       = 2'h1;
  localparam logic [1:0]  SRC_NONE      = 2'h2;
  localparam logic [15:0] DIV_RST       = 16'h0001;
  localparam logic [31:0] THR_RST       = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef struct packed {
    logic [1:0] close_mode;
    logic [1:0] dsel;
    logic [1:0] src;
    logic       dir;
    logic [4:0] do_a_func;
    logic [4:0] do_b_func;
  } pdpd_cfg_t;

  typedef struct packed {
    logic [1:0]  src;
    logic        dir;
    logic [15:0] factor;
  } pdpd_act_t;

  localparam pdpd_cfg_t CFG_RST = '{MODE_OFF, DSEL_FUNC, SRC_MOTOR, 1'b0, 5'h00, 5'h00};
  localparam pdpd_act_t ACT_RST = '{SRC_MOTOR, 1'b0, DIV_RST};
endpackage

// >>> core/pdpd_div.sv
/*
  pulse divider: one output pulse for every factor input pulses.
  assumes in_pulse is a one-cycle strobe; a factor of zero acts as one.
*/
`timescale 1ns/1ps
module pdpd_div #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         clr,
  input  wire logic [W-1:0] factor,
  input  wire logic         in_pulse,
  output logic              out_pulse
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         out_nxt;
  logic [W-1:0] last;

  assign last = (factor == '0) ? '0 : factor - W'(1);

  always_comb begin
    cnt_nxt = cnt_r;
    out_nxt = 1'b0;
    if (clr) begin
      cnt_nxt = '0;
    end else if (in_pulse) begin
      if (cnt_r >= last) begin
        cnt_nxt = '0;
        out_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r     <= '0;
      out_pulse <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      out_pulse <= out_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_div_fire_count: assert property (
    out_pulse |-> $past(in_pulse) && !$past(clr) && ($past(cnt_r) >= $past(last)))
    else $error("divider fired before the count reached the factor");
  a_div_restart: assert property (
    out_pulse |-> cnt_r == '0)
    else $error("divider did not restart after firing");
endmodule // pdpd_div

// >>> core/pdpd_top.sv
/*
  positioning completion and close flags, plus divided encoder pulse output,
  with an AXI4-Lite register slave.
  assumes all inputs synchronous to REF_CLK; pulse inputs are one-cycle strobes.
*/
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module pdpd_top #(
  parameter int OC_GAP = pdpd_pkg::OC_GAP_CYC,
  parameter int DIV_W  = 16
) (
  input  wire logic        REF_CLK,
  input  wire logic        RSTN,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic [31:0] POS_ERR,
  input  wire logic [31:0] POSITION_SPEED_COMMAND_VALUE,
  input  wire logic [31:0] FILTERED_POSITION_SPEED_COMMAND,
  input  wire logic        MOTOR_PULSE,
  input  wire logic        MOTOR_DIR,
  input  wire logic        CMD_PULSE,
  input  wire logic        CMD_DIR,
  input  wire logic [1:0]  DIFF_IN,
  output logic             COMPLETE,
  output logic             CLOSE,
  output logic             OPEN_COLLECTOR_OUT_A,
  output logic             OPEN_COLLECTOR_OUT_B,
  output logic             DIFF_PULSE_O,
  output logic             DIFF_DIR_O,
  output logic             DIFF_OE
);
  pdpd_pkg::pdpd_cfg_t cfg_r, cfg_nxt;
  pdpd_pkg::pdpd_act_t act_r, act_nxt;
  logic [31:0] appr_thr_r, appr_thr_nxt, done_thr_r, done_thr_nxt;
  logic [31:0] hold_r, hold_nxt;
  logic [15:0] div_r, div_nxt;
  logic        apply;

  // bus handshake state
  logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic        wr_fire;

  assign AWREADY = !aw_got_r && !bvalid_r;
  assign WREADY  = !w_got_r && !bvalid_r;
  assign ARREADY = !rvalid_r;
  assign BVALID  = bvalid_r;
  assign BRESP   = bresp_r;
  assign RVALID  = rvalid_r;
  assign RDATA   = rdata_r;
  assign RRESP   = rresp_r;
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) old[8*i +: 8] = d[8*i +: 8];
    end
    return old;
  endfunction

  // flags state
  logic [31:0] abs_err;
  logic        in_close_band, in_done_band;
  logic [31:0] hold_cnt_r, hold_cnt_nxt;
  logic        close_r, close_nxt, done_r, done_nxt;

  always_comb begin
    logic [31:0] c;
    c = '0;
    cfg_nxt      = cfg_r;
    appr_thr_nxt = appr_thr_r;
    done_thr_nxt = done_thr_r;
    hold_nxt     = hold_r;
    div_nxt      = div_r;
    aw_got_nxt   = aw_got_r || (AWVALID && AWREADY);
    w_got_nxt    = w_got_r || (WVALID && WREADY);
    awaddr_nxt   = (AWVALID && AWREADY) ? AWADDR : awaddr_r;
    wdata_nxt    = (WVALID && WREADY) ? WDATA : wdata_r;
    wstrb_nxt    = (WVALID && WREADY) ? WSTRB : wstrb_r;
    bvalid_nxt   = bvalid_r && !BREADY;
    bresp_nxt    = bresp_r;
    apply        = 1'b0;
    if (wr_fire) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = pdpd_pkg::RESP_OKAY;
      unique case (awaddr_r)
        pdpd_pkg::ADDR_CTRL: begin
          c = merge({25'h0, cfg_r.dir, cfg_r.src, cfg_r.dsel, cfg_r.close_mode},
                    wdata_r, wstrb_r);
          cfg_nxt.close_mode = c[pdpd_pkg::CTRL_MODE_LSB +: 2];
          cfg_nxt.dsel       = c[pdpd_pkg::CTRL_DSEL_LSB +: 2];
          cfg_nxt.src        = c[pdpd_pkg::CTRL_SRC_LSB +: 2];
          cfg_nxt.dir        = c[pdpd_pkg::CTRL_DIR_BIT];
        end
        pdpd_pkg::ADDR_APPR_THR: appr_thr_nxt = merge(appr_thr_r, wdata_r, wstrb_r);
        pdpd_pkg::ADDR_DONE_THR: done_thr_nxt = merge(done_thr_r, wdata_r, wstrb_r);
        pdpd_pkg::ADDR_HOLD:     hold_nxt     = merge(hold_r, wdata_r, wstrb_r);
        pdpd_pkg::ADDR_DIV: begin
          c = merge({16'h0, div_r}, wdata_r, wstrb_r);
          // zero is outside the range, keep old value
          if (c[15:0] != 16'h0000) div_nxt = c[15:0];
        end
        pdpd_pkg::ADDR_DO_SEL: begin
          c = merge({19'h0, cfg_r.do_b_func, 3'h0, cfg_r.do_a_func}, wdata_r, wstrb_r);
          cfg_nxt.do_a_func = c[4:0];
          cfg_nxt.do_b_func = c[pdpd_pkg::DOB_LSB +: 5];
        end
        pdpd_pkg::ADDR_APPLY: apply = wstrb_r[0] && wdata_r[0];
        pdpd_pkg::ADDR_STATUS: ;
        default: bresp_nxt = pdpd_pkg::RESP_SLVERR;
      endcase
    end
    rvalid_nxt = rvalid_r && !RREADY;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (ARVALID && ARREADY) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = pdpd_pkg::RESP_OKAY;
      unique case (ARADDR)
        pdpd_pkg::ADDR_CTRL:
          rdata_nxt = {25'h0, cfg_r.dir, cfg_r.src, cfg_r.dsel, cfg_r.close_mode};
        pdpd_pkg::ADDR_APPR_THR: rdata_nxt = appr_thr_r;
        pdpd_pkg::ADDR_DONE_THR: rdata_nxt = done_thr_r;
        pdpd_pkg::ADDR_HOLD:     rdata_nxt = hold_r;
        pdpd_pkg::ADDR_DIV:      rdata_nxt = {16'h0, div_r};
        pdpd_pkg::ADDR_DO_SEL:   rdata_nxt = {19'h0, cfg_r.do_b_func, 3'h0, cfg_r.do_a_func};
        pdpd_pkg::ADDR_STATUS:
          rdata_nxt = {act_r.factor, 9'h0, DIFF_IN, act_r.dir, act_r.src, close_r, done_r};
        pdpd_pkg::ADDR_APPLY:    rdata_nxt = '0;
        default: begin
          rdata_nxt = '0;
          rresp_nxt = pdpd_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // divider settings become active only on apply
  always_comb begin
    act_nxt = act_r;
    if (apply) act_nxt = '{cfg_r.src, cfg_r.dir, div_r};
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_r      <= pdpd_pkg::CFG_RST;
      act_r      <= pdpd_pkg::ACT_RST;
      appr_thr_r <= pdpd_pkg::THR_RST;
      done_thr_r <= pdpd_pkg::THR_RST;
      hold_r     <= pdpd_pkg::THR_RST;
      div_r      <= pdpd_pkg::DIV_RST;
      aw_got_r   <= 1'b0;
      w_got_r    <= 1'b0;
      bvalid_r   <= 1'b0;
      rvalid_r   <= 1'b0;
      awaddr_r   <= '0;
      wdata_r    <= '0;
      wstrb_r    <= '0;
      rdata_r    <= '0;
      bresp_r    <= pdpd_pkg::RESP_OKAY;
      rresp_r    <= pdpd_pkg::RESP_OKAY;
    end else begin
      cfg_r      <= cfg_nxt;
      act_r      <= act_nxt;
      appr_thr_r <= appr_thr_nxt;
      done_thr_r <= done_thr_nxt;
      hold_r     <= hold_nxt;
      div_r      <= div_nxt;
      aw_got_r   <= aw_got_nxt;
      w_got_r    <= w_got_nxt;
      bvalid_r   <= bvalid_nxt;
      rvalid_r   <= rvalid_nxt;
      awaddr_r   <= awaddr_nxt;
      wdata_r    <= wdata_nxt;
      wstrb_r    <= wstrb_nxt;
      rdata_r    <= rdata_nxt;
      bresp_r    <= bresp_nxt;
      rresp_r    <= rresp_nxt;
    end
  end

  assign abs_err       = POS_ERR[31] ? (~POS_ERR + 32'h0000_0001) : POS_ERR;
  assign in_close_band = abs_err < appr_thr_r;
  assign in_done_band  = abs_err < done_thr_r;

  always_comb begin
    close_nxt    = 1'b0;
    hold_cnt_nxt = in_done_band ? hold_cnt_r : '0;
    // hold counter saturates at the programmed time
    if (in_done_band && hold_cnt_r < hold_r) hold_cnt_nxt = hold_cnt_r + 32'h0000_0001;
    done_nxt = in_done_band && (hold_cnt_nxt >= hold_r);
    unique case (cfg_r.close_mode)
      pdpd_pkg::MODE_OFF: close_nxt = 1'b0;
      pdpd_pkg::MODE_SPD:
        close_nxt = in_close_band && (POSITION_SPEED_COMMAND_VALUE == '0);
      pdpd_pkg::MODE_FILT:
        close_nxt = in_close_band && (FILTERED_POSITION_SPEED_COMMAND == '0);
      pdpd_pkg::MODE_LATCH:
        close_nxt = (POSITION_SPEED_COMMAND_VALUE == '0) && (close_r || in_close_band);
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      hold_cnt_r <= '0;
      close_r    <= 1'b0;
      done_r     <= 1'b0;
    end else begin
      hold_cnt_r <= hold_cnt_nxt;
      close_r    <= close_nxt;
      done_r     <= done_nxt;
    end
  end

  // pulse path: one shared divider for both output ports
  logic        div_pulse;
  logic        mdir;
  logic        oc_pend_r, oc_pend_nxt, oc_tog_r, oc_tog_nxt, oc_dir_r, oc_dir_nxt;
  logic [31:0] oc_gap_r, oc_gap_nxt;
  logic        oc_fire;
  logic        dp_r, dp_nxt, dd_r, dd_nxt, do_a_r, do_a_nxt, do_b_r, do_b_nxt;

  pdpd_div #(.W(DIV_W)) u_div (
    .clk       (REF_CLK),
    .rstn      (RSTN),
    .clr       (apply),
    .factor    (act_r.factor),
    .in_pulse  (MOTOR_PULSE),
    .out_pulse (div_pulse)
  );

  // sense inversion only on motor pulses
  assign mdir    = MOTOR_DIR ^ act_r.dir;
  assign oc_fire = oc_pend_r && (oc_gap_r == '0);

  function automatic logic do_func(input logic [4:0] f, input logic d, input logic c);
    return (f == pdpd_pkg::FUNC_DONE) ? d : (f == pdpd_pkg::FUNC_CLOSE) ? c : 1'b0;
  endfunction

  always_comb begin
    // excess pulses beyond one pending are dropped to cap the rate
    oc_pend_nxt = (oc_pend_r && !oc_fire) || div_pulse;
    oc_dir_nxt  = div_pulse ? mdir : oc_dir_r;
    oc_gap_nxt  = oc_fire ? 32'(OC_GAP - 1) : (oc_gap_r != '0) ? oc_gap_r - 32'h1 : '0;
    oc_tog_nxt  = oc_tog_r ^ oc_fire;
    unique case (act_r.src)
      pdpd_pkg::SRC_CMD: begin
        dp_nxt = CMD_PULSE;
        dd_nxt = CMD_DIR;
      end
      pdpd_pkg::SRC_MOTOR: begin
        dp_nxt = div_pulse;
        dd_nxt = div_pulse ? mdir : dd_r;
      end
      default: begin
        dp_nxt = 1'b0;
        dd_nxt = 1'b0;
      end
    endcase
    if (cfg_r.dsel == pdpd_pkg::DSEL_PULSE) begin
      do_a_nxt = oc_tog_r;
      do_b_nxt = oc_dir_r;
    end else if (cfg_r.dsel == pdpd_pkg::DSEL_FUNC) begin
      do_a_nxt = do_func(cfg_r.do_a_func, done_r, close_r);
      do_b_nxt = do_func(cfg_r.do_b_func, done_r, close_r);
    end else begin
      do_a_nxt = 1'b0;
      do_b_nxt = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      oc_pend_r <= 1'b0;
      oc_dir_r  <= 1'b0;
      oc_gap_r  <= '0;
      oc_tog_r  <= 1'b0;
      dp_r      <= 1'b0;
      dd_r      <= 1'b0;
      do_a_r    <= 1'b0;
      do_b_r    <= 1'b0;
    end else begin
      oc_pend_r <= oc_pend_nxt;
      oc_dir_r  <= oc_dir_nxt;
      oc_gap_r  <= oc_gap_nxt;
      oc_tog_r  <= oc_tog_nxt;
      dp_r      <= dp_nxt;
      dd_r      <= dd_nxt;
      do_a_r    <= do_a_nxt;
      do_b_r    <= do_b_nxt;
    end
  end

  assign COMPLETE             = done_r;
  assign CLOSE                = close_r;
  assign OPEN_COLLECTOR_OUT_A = do_a_r;
  assign OPEN_COLLECTOR_OUT_B = do_b_r;
  assign DIFF_PULSE_O         = dp_r;
  assign DIFF_DIR_O           = dd_r;
  // source 2 releases the port as input
  assign DIFF_OE              = (act_r.src == pdpd_pkg::SRC_MOTOR) ||
                                (act_r.src == pdpd_pkg::SRC_CMD);

  // assertion helper: cycles since the last paced edge, kept apart from the gap counter
  logic [31:0] oc_since_r, oc_since_nxt;

  always_comb begin
    oc_since_nxt = oc_since_r;
    if (oc_fire) oc_since_nxt = '0;
    else if (oc_since_r != '1) oc_since_nxt = oc_since_r + 32'h0000_0001;
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      oc_since_r <= '1;
    end else begin
      oc_since_r <= oc_since_nxt;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  a_close_mode_one: assert property (
    (cfg_r.close_mode == 2'h1) |-> ##1 (close_r == $past(in_close_band &&
      POSITION_SPEED_COMMAND_VALUE == '0)))
    else $error("close flag wrong in mode one");
  a_close_mode_two: assert property (
    (cfg_r.close_mode == 2'h2) |-> ##1 (close_r == $past(in_close_band &&
      FILTERED_POSITION_SPEED_COMMAND == '0)))
    else $error("close flag wrong in mode two");
  a_close_latch_hold: assert property (
    (cfg_r.close_mode == 2'h3 && close_r && POSITION_SPEED_COMMAND_VALUE == '0) |=> close_r)
    else $error("latched close dropped while speed is zero");
  a_close_needs_band: assert property (
    (cfg_r.close_mode inside {2'h1, 2'h2} && abs_err >= appr_thr_r) |=> !CLOSE)
    else $error("close raised outside the approach band");
  a_done_needs_band: assert property (
    !in_done_band |=> !COMPLETE)
    else $error("completion raised outside the band");
  a_done_after_hold: assert property (
    $rose(COMPLETE) |-> $past(hold_cnt_r) + 32'h1 >= $past(hold_r) || $past(hold_r) == '0)
    else $error("completion raised before the hold time");
  a_do_func_done: assert property (
    (cfg_r.dsel == 2'h0 && cfg_r.do_a_func == 5'h0D) |=> OPEN_COLLECTOR_OUT_A == $past(done_r))
    else $error("output code 13 does not follow completion");
  a_do_func_close: assert property (
    (cfg_r.dsel == 2'h0 && cfg_r.do_b_func == 5'h0E) |=> OPEN_COLLECTOR_OUT_B == $past(close_r))
    else $error("output code 14 does not follow close");
  a_oc_rate_gap: assert property (
    oc_fire |-> oc_since_r >= 32'(OC_GAP - 1))
    else $error("open-collector edges closer than the rate cap");
  a_cmd_passes: assert property (
    (act_r.src == 2'h1 && CMD_PULSE) |=> DIFF_PULSE_O)
    else $error("command pulse did not pass through");
  a_src_none_off: assert property (
    (act_r.src == 2'h2) |-> !DIFF_OE ##1 !DIFF_PULSE_O)
    else $error("port driven while source is input");
endmodule // pdpd_top

// >>> bench/pdpd_far_end.sv
/*
  far-side model: an external counter of differential and open-collector pulses.
  assumes the block's outputs are synchronous to clk; drives the port pins as inputs.
*/
`timescale 1ns/1ps
module pdpd_far_end (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        diff_pulse,
  input  wire logic        diff_oe,
  input  wire logic        oc_a,
  input  wire logic [1:0]  pin_lvl,
  output logic [1:0]       diff_in,
  output logic [15:0]      diff_cnt,
  output logic [15:0]      oc_cnt
);
  logic oc_a_d;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      diff_cnt <= 16'h0000;
      oc_cnt   <= 16'h0000;
      oc_a_d   <= 1'h0;
      diff_in  <= 2'h1;
    end else begin
      if (diff_pulse) begin
        diff_cnt <= diff_cnt + 16'h0001;
      end
      // open-collector pulses arrive as level toggles
      if (oc_a != oc_a_d) begin
        oc_cnt <= oc_cnt + 16'h0001;
      end
      oc_a_d  <= oc_a;
      // while the block drives the pins our input side sees only a moving pattern
      diff_in <= diff_oe ? ~diff_in : pin_lvl;
    end
  end
endmodule // pdpd_far_end

// >>> bench/position_done_and_pulse_divider_tb.sv
/*
  self-checking bench for the positioning flags and pulse divider block.
  assumes the block's AXI4-Lite slave and a far-end pulse counter model.
*/
`timescale 1ns/1ps
module position_done_and_pulse_divider_tb;
  logic        clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, mpul, mdir, cpul, cdir;
  logic        done, close, oca, ocb, dpul, ddir, doe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, pos_err, spd, fspd, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, pin_lvl, diff_in, rs;
  logic [15:0] diff_cnt, oc_cnt, c0;
  int          err_count = 0;
  int          n_checks = 0;

  pdpd_top #(.OC_GAP(8)) dut_u (
    .REF_CLK(clk), .RSTN(rstn), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .POS_ERR(pos_err), .POSITION_SPEED_COMMAND_VALUE(spd),
    .FILTERED_POSITION_SPEED_COMMAND(fspd), .MOTOR_PULSE(mpul), .MOTOR_DIR(mdir),
    .CMD_PULSE(cpul), .CMD_DIR(cdir), .DIFF_IN(diff_in), .COMPLETE(done), .CLOSE(close),
    .OPEN_COLLECTOR_OUT_A(oca), .OPEN_COLLECTOR_OUT_B(ocb), .DIFF_PULSE_O(dpul),
    .DIFF_DIR_O(ddir), .DIFF_OE(doe));

  pdpd_far_end far_u (
    .clk(clk), .rstn(rstn), .diff_pulse(dpul), .diff_oe(doe), .oc_a(oca),
    .pin_lvl(pin_lvl), .diff_in(diff_in), .diff_cnt(diff_cnt), .oc_cnt(oc_cnt));

  task automatic give_verdict;
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic tmo;
    err_count++;
    $display("ERROR %0t bus answer never came", $time);
    give_verdict();
  endtask

  task automatic look(input int n);
    repeat (n) @(negedge clk);
  endtask

  // readies are sampled mid-cycle, where they hold their value for the next edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    tb = 0;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rs = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb) bready <= 1'h0;
    end
    if (!tb) tmo();
    chk(rs, er, "write response");
  endtask

  task automatic axr(input logic [7:0] a, input logic [1:0] er);
    bit ta, tb;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    tb = 0;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge clk);
      ta = arvalid && arready;
      tb = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'h0;
      if (tb) rready <= 1'h0;
    end
    if (!tb) tmo();
    chk(rs, er, "read response");
  endtask

  task automatic setin(input logic [31:0] e, input logic [31:0] s, input logic [31:0] f);
    @(posedge clk);
    pos_err <= e;
    spd <= s;
    fspd <= f;
    look(3);
  endtask

  task automatic pulses(input bit cmd, input logic dir, input int n, input int gap);
    repeat (n) begin
      @(posedge clk);
      mdir <= dir;
      cdir <= dir;
      if (cmd) cpul <= 1'h1;
      else mpul <= 1'h1;
      @(posedge clk);
      cpul <= 1'h0;
      mpul <= 1'h0;
      repeat (gap) @(posedge clk);
    end
  endtask

  task automatic t_regs;
    chk(doe, 1'h1, "port driven after reset");
    axr(pdpd_pkg::ADDR_DIV, pdpd_pkg::RESP_OKAY);
    chk(rd, 32'h0000_0001, "factor reset value");
    axr(8'h40, pdpd_pkg::RESP_SLVERR);
    chk(rd, 32'h0000_0000, "unmapped read data");
    axw(8'h40, 32'h0000_0005, pdpd_pkg::RESP_SLVERR);
    axr(pdpd_pkg::ADDR_CTRL, pdpd_pkg::RESP_OKAY);
    chk(rd, 32'h0000_0000, "control reset value");
  endtask

  task automatic t_done;
    // error starts outside the band so the hold count begins at zero
    setin(32'h0000_0064, 32'h0000_0000, 32'h0000_0000);
    axw(pdpd_pkg::ADDR_DONE_THR, 32'h0000_000A, pdpd_pkg::RESP_OKAY);
    // approach kept above completion by the configuring side
    axw(pdpd_pkg::ADDR_APPR_THR, 32'h0000_0014, pdpd_pkg::RESP_OKAY);
    axw(pdpd_pkg::ADDR_HOLD, 32'h0000_0003, pdpd_pkg::RESP_OKAY);
    axw(pdpd_pkg::ADDR_DO_SEL, 32'h0000_0E0D, pdpd_pkg::RESP_OKAY);
    axw(pdpd_pkg::ADDR_CTRL, 32'h0000_0001, pdpd_pkg::RESP_OKAY);
    setin(32'hFFFF_FFF7, 32'h0000_0000, 32'h0000_0000);
    chk(done, 1'h0, "completion before hold time");
    chk(close, 1'h1, "close in mode 1");
    look(3);
    chk(done, 1'h1, "completion after hold time");
    chk(oca, 1'h1, "output code 13");
    chk(ocb, 1'h1, "output code 14");
    setin(32'hFFFF_FFF6, 32'h0000_0000, 32'h0000_0000);
    chk(done, 1'h0, "completion at threshold");
    chk(oca, 1'h0, "output code 13 cleared");
  endtask

  task automatic t_close;
    setin(32'hFFFF_FFF6, 32'h0000_0001, 32'h0000_0000);
    chk(close, 1'h0, "mode 1 speed nonzero");
    setin(32'hFFFF_FFEC, 32'h0000_0000, 32'h0000_0000);
    chk(close, 1'h0, "close at approach threshold");
    chk(ocb, 1'h0, "output code 14 cleared");
    axw(pdpd_pkg::ADDR_CTRL, 32'h0000_0002, pdpd_pkg::RESP_OKAY);
    setin(32'hFFFF_FFED, 32'h0000_0001, 32'h0000_0000);
    chk(close, 1'h1, "mode 2 filtered zero");
    setin(32'hFFFF_FFED, 32'h0000_0000, 32'h0000_0001);
    chk(close, 1'h0, "mode 2 filtered nonzero");
    axw(pdpd_pkg::ADDR_CTRL, 32'h0000_0003, pdpd_pkg::RESP_OKAY);
    setin(32'hFFFF_FFED, 32'h0000_0000, 32'h0000_0000);
    chk(close, 1'h1, "mode 3 set");
    setin(32'h0000_0064, 32'h0000_0000, 32'h0000_0000);
    chk(close, 1'h1, "mode 3 holds on large error");
    setin(32'h0000_0064, 32'h0000_0001, 32'h0000_0000);
    chk(close, 1'h0, "mode 3 cleared by speed");
  endtask

  task automatic t_div;
    axw(pdpd_pkg::ADDR_DIV, 32'h0000_0003, pdpd_pkg::RESP_OKAY);
    axr(pdpd_pkg::ADDR_STATUS, pdpd_pkg::RESP_OKAY);
    chk(rd[31:16], 16'h0001, "factor before apply");
    axw(pdpd_pkg::ADDR_APPLY, 32'h0000_0001, pdpd_pkg::RESP_OKAY);
    axr(pdpd_pkg::ADDR_STATUS, pdpd_pkg::RESP_OKAY);
    chk(rd[31:16], 16'h0003, "factor after apply");
    c0 = diff_cnt;
    pulses(0, 1'h1, 8, 2);
    look(4);
    chk(diff_cnt - c0, 16'h0002, "divide by 3");
    chk(ddir, 1'h1, "forward sense");
    pulses(0, 1'h1, 1, 2);
    look(4);
    chk(diff_cnt - c0, 16'h0003, "count restarts");
    axw(pdpd_pkg::ADDR_CTRL, 32'h0000_0040, pdpd_pkg::RESP_OKAY);
    axw(pdpd_pkg::ADDR_APPLY, 32'h0000_0001, pdpd_pkg::RESP_OKAY);
    pulses(0, 1'h0, 3, 2);
    look(4);
    chk(diff_cnt - c0, 16'h0004, "divided after apply");
    chk(ddir, 1'h1, "reverse sense");
    // full closed loop is never enabled here, so the differential port is free
    axw(pdpd_pkg::ADDR_CTRL, 32'h0000_0050, pdpd_pkg::RESP_OKAY);
    axw(pdpd_pkg::ADDR_APPLY, 32'h0000_0001, pdpd_pkg::RESP_OKAY);
    pulses(1, 1'h0, 4, 1);
    look(4);
    chk(diff_cnt - c0, 16'h0008, "commands undivided");
    chk(ddir, 1'h0, "command sense not inverted");
    axw(pdpd_pkg::ADDR_CTRL, 32'h0000_0020, pdpd_pkg::RESP_OKAY);
    axw(pdpd_pkg::ADDR_APPLY, 32'h0000_0001, pdpd_pkg::RESP_OKAY);
    @(posedge clk);
    pin_lvl <= 2'h2;
    look(4);
    chk(doe, 1'h0, "port released as input");
    axr(pdpd_pkg::ADDR_STATUS, pdpd_pkg::RESP_OKAY);
    chk(rd[6:5], 2'h2, "port input level");
  endtask

  task automatic t_oc;
    axw(pdpd_pkg::ADDR_CTRL, 32'h0000_0004, pdpd_pkg::RESP_OKAY);
    axw(pdpd_pkg::ADDR_DIV, 32'h0000_0001, pdpd_pkg::RESP_OKAY);
    axw(pdpd_pkg::ADDR_APPLY, 32'h0000_0001, pdpd_pkg::RESP_OKAY);
    c0 = oc_cnt;
    pulses(0, 1'h1, 2, 10);
    look(12);
    chk(oc_cnt - c0, 16'h0002, "open-collector pulses");
    chk(ocb, 1'h1, "open-collector direction");
    // a burst faster than the rate cap keeps one pending and drops the rest
    pulses(0, 1'h1, 3, 0);
    look(24);
    chk(oc_cnt - c0, 16'h0004, "rate cap drops excess");
    axw(pdpd_pkg::ADDR_CTRL, 32'h0000_0008, pdpd_pkg::RESP_OKAY);
    look(2);
    chk(ocb, 1'h0, "outputs low for select 2");
  endtask

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, mpul, mdir, cpul, cdir} = '0;
    {awaddr, araddr, wdata, pos_err, spd, fspd, pin_lvl} = '0;
    wstrb = 4'hF;
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    t_regs();
    t_done();
    t_close();
    t_div();
    t_oc();
    give_verdict();
  end
endmodule // position_done_and_pulse_divider_tb
